// File: core/dja_pkg.sv
// Shared constants, types and decoders for the jitter attenuator control
package dja_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_NS   = 25;                // REF_CLK period
    localparam int          UI_NS    = 488;               // Nominal line bit period
    localparam int          NOM_CYC  = UI_NS / CLK_NS;    // Clocks per smooth bit
    localparam logic [4:0]  NOM_PER  = 5'(NOM_CYC - 1);   // Terminal count of period
    localparam logic [8:0]  SELF_CENTER_ENABLE_UI  = 9'h180;            // Self-centre window, 384 UI
    localparam logic [5:0]  SELF_CENTER_ENABLE_MRG = 6'h04;             // Least distance from edges

    ////////////////////////////////////////////////////////////////////////////
    // FIFO geometry
    localparam int          DEPTH    = 32;
    localparam int          AW       = 5;
    localparam logic [5:0]  FULL_LVL = 6'h20;
    localparam logic [5:0]  HALF_LVL = 6'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices (byte address is four times the index)
    localparam logic [7:0]  IDX_STATUS  = 8'h18;
    localparam logic [7:0]  IDX_REF_DIV = 8'h19;
    localparam logic [7:0]  IDX_OUT_DIV = 8'h1A;
    localparam logic [7:0]  IDX_CONFIG  = 8'h1B;

    // Reset values
    localparam logic [7:0]  DIV_RST = 8'h2F;
    localparam logic [5:0]  CFG_RST = 6'h23;

    // Field positions
    localparam int          CFG_SELF_CENTER_ENABLE = 4;
    localparam int          ST_OVR   = 1;
    localparam int          ST_UND   = 0;

    // Configuration register layout, bit 5 down to bit 0
    typedef struct packed {
        logic reserved;
        logic self_center_enable;
        logic underrun_int_enable;
        logic overrun_int_enable;
        logic sync;
        logic limit;
    } dja_cfg_t;

    // Word address match for an index
    function automatic logic dja_hit(input logic [7:0] addr, input logic [7:0] idx);
        return addr == {idx[5:0], 2'b00};
    endfunction : dja_hit

endpackage : dja_pkg

// File: core/dja_div.sv
// Programmable divide-by-(value+1) pulse divider
`timescale 1ns/1ps
`default_nettype none
module dja_div
    import dja_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       tick_in,
    input  wire logic [7:0] div,
    output logic            tick_out
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } dja_div_st_t;

    dja_div_st_t s_q;
    dja_div_st_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // Count input pulses, emit one every div+1
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (clr) begin
            s_d.cnt = 8'h00;
        end else if (tick_in) begin
            if (s_q.cnt >= div) begin
                s_d.cnt  = 8'h00;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.tick;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_div_tick;
        @(posedge clk) disable iff (rst)
        tick_out |-> $past(tick_in) && !$past(clr) && ($past(s_q.cnt) >= $past(div));
    endproperty
    a_div_tick: assert property (p_div_tick) else $error("divider pulse off count");

endmodule : dja_div
`default_nettype wire

// File: core/dja_ctrl.sv
// Jitter attenuator control: divisors, PLL, elastic FIFO, registers, interrupt
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module dja_ctrl
    import dja_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    input  wire logic [7:0]  ADDRESS,
    input  wire logic        READ,
    input  wire logic        WRITE,
    input  wire logic [31:0] WRITEDATA,
    input  wire logic [3:0]  BYTEENABLE,
    output logic      [31:0] READDATA,
    output logic             WAITREQUEST,
    input  wire logic        IN_VALID,
    input  wire logic        IN_DATA,
    output logic             OUT_DATA,
    output logic             OUT_STROBE,
    output logic             IRQ_OUT_N
);

    typedef struct packed {
        logic [7:0]        ref_div;
        logic [7:0]        out_div;
        dja_cfg_t          cfg;
        logic              ovr;
        logic              und;
        logic              irq;
        logic              ack;
        logic [7:0]        rdata;
        logic [DEPTH-1:0]  mem;
        logic [AW-1:0]     wr_ptr;
        logic [AW-1:0]     rd_ptr;
        logic [5:0]        fill;
        logic [5:0]        lag;
        logic [4:0]        per_cnt;
        logic signed [9:0] phase;
        logic [8:0]        self_center_enable_cnt;
        logic              out_data;
        logic              out_stb;
    } dja_st_t;

    dja_st_t s_q;
    dja_st_t s_d;

    logic       req;
    logic       acc;
    logic       wr_acc;
    logic       ref_wr;
    logic       out_wr;
    logic       pll_clr;
    logic       fifo_clr;
    logic       out_tick;
    logic       ref_tick;
    logic       fb_tick;
    logic       speed_up;
    logic       slow_down;
    logic [4:0] per_end;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait state, request taken on second edge
    assign req         = READ | WRITE;
    assign acc         = req & s_q.ack;
    assign WAITREQUEST = req & ~s_q.ack;
    assign wr_acc      = WRITE & s_q.ack & BYTEENABLE[0];
    assign ref_wr      = wr_acc & dja_hit(ADDRESS, IDX_REF_DIV);
    assign out_wr      = wr_acc & dja_hit(ADDRESS, IDX_OUT_DIV);
    assign pll_clr     = ref_wr | out_wr;
    assign fifo_clr    = pll_clr & s_q.cfg.sync;

    ////////////////////////////////////////////////////////////////////////////
    // Smooth clock period steering
    always_comb begin
        speed_up  = 1'b0;
        slow_down = 1'b0;
        if (s_q.cfg.limit && s_q.fill >= FULL_LVL - 6'h01) begin
            speed_up = 1'b1;
        end else if (s_q.cfg.limit && s_q.fill <= 6'h01) begin
            slow_down = 1'b1;
        end else if (s_q.phase > 10'sd0) begin
            speed_up = 1'b1;
        end else if (s_q.phase < 10'sd0) begin
            slow_down = 1'b1;
        end
    end

    // Terminal count of the current smooth bit
    assign per_end  = speed_up  ? NOM_PER - 5'h01 :
                      slow_down ? NOM_PER + 5'h01 : NOM_PER;
    assign out_tick = (s_q.per_cnt >= per_end);

    ////////////////////////////////////////////////////////////////////////////
    // Phase detector inputs
    dja_div u_ref_div (
        .clk      (REF_CLK),
        .rst      (SYS_RST),
        .clr      (pll_clr),
        .tick_in  (IN_VALID),
        .div      (s_q.ref_div),
        .tick_out (ref_tick)
    );

    dja_div u_out_div (
        .clk      (REF_CLK),
        .rst      (SYS_RST),
        .clr      (pll_clr),
        .tick_in  (out_tick),
        .div      (s_q.out_div),
        .tick_out (fb_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic       ovr_ev;
        logic       und_ev;
        logic       wr_ok;
        logic       rd_ok;
        logic       st_rd;
        logic       self_center_enable_up;
        logic [5:0] fill_t;
        ovr_ev  = 1'b0;
        und_ev  = 1'b0;
        wr_ok   = 1'b0;
        rd_ok   = 1'b0;
        st_rd   = READ & acc & dja_hit(ADDRESS, IDX_STATUS);
        self_center_enable_up = 1'b0;
        s_d     = s_q;

        // Bus side
        s_d.ack = req & ~s_q.ack;
        if (req && !s_q.ack) begin
            if (dja_hit(ADDRESS, IDX_STATUS)) begin
                s_d.rdata = {6'h00, s_q.ovr, s_q.und};
            end else if (dja_hit(ADDRESS, IDX_REF_DIV)) begin
                s_d.rdata = s_q.ref_div;
            end else if (dja_hit(ADDRESS, IDX_OUT_DIV)) begin
                s_d.rdata = s_q.out_div;
            end else if (dja_hit(ADDRESS, IDX_CONFIG)) begin
                s_d.rdata = {2'b00, s_q.cfg};
            end else begin
                s_d.rdata = 8'h00;
            end
        end
        if (ref_wr) begin
            s_d.ref_div = WRITEDATA[7:0];
        end
        if (out_wr) begin
            s_d.out_div = WRITEDATA[7:0];
        end
        if (wr_acc && dja_hit(ADDRESS, IDX_CONFIG)) begin
            s_d.cfg = dja_cfg_t'(WRITEDATA[5:0]);
            self_center_enable_up = WRITEDATA[CFG_SELF_CENTER_ENABLE] & ~s_q.cfg.self_center_enable;
        end

        // FIFO write from the jittered side
        if (IN_VALID) begin
            if (s_q.fill == FULL_LVL) begin
                ovr_ev = 1'b1;
            end else begin
                wr_ok                = 1'b1;
                s_d.mem[s_q.wr_ptr]  = IN_DATA;
                s_d.wr_ptr           = s_q.wr_ptr + 5'h01;
            end
        end

        // FIFO read on the smooth side
        s_d.out_stb = out_tick;
        if (out_tick) begin
            if (s_q.fill == 6'h00) begin
                und_ev = 1'b1;
            end else begin
                rd_ok        = 1'b1;
                s_d.out_data = s_q.mem[s_q.rd_ptr];
                s_d.rd_ptr   = s_q.rd_ptr + 5'h01;
            end
        end
        fill_t   = s_q.fill + {5'h00, wr_ok} - {5'h00, rd_ok};
        s_d.fill = fill_t;

        // Smooth period counter and phase error
        s_d.per_cnt = out_tick ? 5'h00 : s_q.per_cnt + 5'h01;
        s_d.phase   = s_q.phase + (ref_tick ? 10'sd1 : 10'sd0) - (fb_tick ? 10'sd1 : 10'sd0);
        if (IN_VALID && !out_tick && s_q.lag != FULL_LVL) begin
            s_d.lag = s_q.lag + 6'h01;
        end else if (out_tick && !IN_VALID && s_q.lag != 6'h00) begin
            s_d.lag = s_q.lag - 6'h01;
        end

        // Sync pulses force FIFO delay to the PLL lag
        if (ref_tick && s_q.cfg.sync) begin
            s_d.rd_ptr = s_d.wr_ptr - s_q.lag[AW-1:0];
            s_d.fill   = s_q.lag;
        end

        // Self-centering window, held while an alarm persists
        if (!s_d.cfg.self_center_enable) begin
            s_d.self_center_enable_cnt = 9'h000;
        end else if (self_center_enable_up || ovr_ev || und_ev) begin
            s_d.self_center_enable_cnt = SELF_CENTER_ENABLE_UI;
        end else if (s_q.self_center_enable_cnt != 9'h000 && out_tick &&
                     s_q.fill != 6'h00 && s_q.fill != FULL_LVL) begin
            s_d.self_center_enable_cnt = s_q.self_center_enable_cnt - 9'h001;
        end
        if (s_q.self_center_enable_cnt != 9'h000 && s_q.cfg.self_center_enable &&
            (fill_t < SELF_CENTER_ENABLE_MRG || fill_t > FULL_LVL - SELF_CENTER_ENABLE_MRG)) begin
            s_d.rd_ptr = s_d.wr_ptr - HALF_LVL[AW-1:0];
            s_d.fill   = HALF_LVL;
        end

        // PLL reset on divisor write, FIFO recentred too when sync is set
        if (pll_clr) begin
            s_d.phase   = 10'sd0;
            s_d.per_cnt = 5'h00;
            s_d.lag     = HALF_LVL;
        end
        if (fifo_clr) begin
            s_d.rd_ptr = s_d.wr_ptr - HALF_LVL[AW-1:0];
            s_d.fill   = HALF_LVL;
        end

        // Sticky flags, set wins over read clear
        s_d.ovr = (s_q.ovr & ~st_rd) | ovr_ev;
        s_d.und = (s_q.und & ~st_rd) | und_ev;
        s_d.irq = (s_d.ovr & s_d.cfg.overrun_int_enable) |
                  (s_d.und & s_d.cfg.underrun_int_enable);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            s_q          <= '0;
            s_q.ref_div  <= DIV_RST;
            s_q.out_div  <= DIV_RST;
            s_q.cfg      <= dja_cfg_t'(CFG_RST);
            s_q.rd_ptr   <= 5'h10;
            s_q.fill     <= HALF_LVL;
            s_q.lag      <= HALF_LVL;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign READDATA   = {24'h000000, s_q.rdata};
    assign OUT_DATA   = s_q.out_data;
    assign OUT_STROBE = s_q.out_stb;
    assign IRQ_OUT_N  = ~s_q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_ref_write;
        WRITE && !WAITREQUEST && BYTEENABLE[0] && dja_hit(ADDRESS, IDX_REF_DIV);
    endsequence

    sequence s_out_write;
        WRITE && !WAITREQUEST && BYTEENABLE[0] && dja_hit(ADDRESS, IDX_OUT_DIV);
    endsequence

    property p_ref_rst;
        $past(SYS_RST) |-> s_q.ref_div == DIV_RST && s_q.out_div == DIV_RST;
    endproperty
    a_ref_rst: assert property (p_ref_rst) else $error("divisor reset value wrong");

    property p_cfg_rst;
        $past(SYS_RST) |-> s_q.cfg == dja_cfg_t'(CFG_RST) && IRQ_OUT_N;
    endproperty
    a_cfg_rst: assert property (p_cfg_rst) else $error("config reset value wrong");

    property p_ref_wr;
        s_ref_write ##0 s_q.cfg.sync |=> s_q.phase == 10'sd0 && s_q.fill == HALF_LVL;
    endproperty
    a_ref_wr: assert property (p_ref_wr) else $error("ref divisor write no reset");

    property p_out_wr;
        s_out_write |=> s_q.phase == 10'sd0 && s_q.per_cnt == 5'h00;
    endproperty
    a_out_wr: assert property (p_out_wr) else $error("out divisor write no reset");

    property p_ovr;
        IN_VALID && s_q.fill == FULL_LVL |=> s_q.ovr;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged");

    property p_und;
        out_tick && s_q.fill == 6'h00 |=> s_q.und ##1 1'b1;
    endproperty
    a_und: assert property (p_und) else $error("underrun not flagged");

    property p_irq;
        s_q.ovr && !s_q.cfg.overrun_int_enable && !s_q.und |-> IRQ_OUT_N;
    endproperty
    a_irq: assert property (p_irq) else $error("masked overrun interrupted");

    property p_irq_en;
        !IRQ_OUT_N |-> (s_q.ovr && s_q.cfg.overrun_int_enable) ||
                       (s_q.und && s_q.cfg.underrun_int_enable);
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("interrupt without enabled flag");

    property p_irq_set;
        IN_VALID && s_q.fill == FULL_LVL && s_q.cfg.overrun_int_enable &&
        !(wr_acc && dja_hit(ADDRESS, IDX_CONFIG)) |=> !IRQ_OUT_N;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("overrun did not interrupt");

    property p_limit;
        s_q.cfg.limit && s_q.fill >= FULL_LVL - 6'h01 |-> per_end == NOM_PER - 5'h01;
    endproperty
    a_limit: assert property (p_limit) else $error("limit did not speed clock");

    property p_self_center_enable;
        s_q.self_center_enable_cnt != 9'h000 && s_q.cfg.self_center_enable && s_q.fill <= SELF_CENTER_ENABLE_MRG &&
            out_tick && !IN_VALID |=> s_q.fill == HALF_LVL;
    endproperty
    a_self_center_enable: assert property (p_self_center_enable) else $error("centering did not recentre");

    property p_self_center_enable_hold;
        s_q.self_center_enable_cnt != 9'h000 && s_q.cfg.self_center_enable &&
            (s_q.fill == 6'h00 || s_q.fill == FULL_LVL) |=>
            s_q.self_center_enable_cnt >= $past(s_q.self_center_enable_cnt) || !s_q.cfg.self_center_enable;
    endproperty
    a_self_center_enable_hold: assert property (p_self_center_enable_hold) else $error("window not extended");

endmodule : dja_ctrl
`default_nettype wire

// File: testbench/dja_framer_model.sv
// Framer data path model feeding bits into the attenuator FIFO
`timescale 1ns/1ps
`default_nettype none
module dja_framer_model
    import dja_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       en,
    input  wire logic [4:0] gap,
    output logic            in_valid,
    output logic            in_data
);
    logic [4:0] cnt_q;
    logic [7:0] pat_q;

    ////////////////////////////////////////////////////////////////////////////
    // One bit every gap+1 clocks while enabled; data toggles when idle
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q    <= 5'h00;
            pat_q    <= 8'h5C;
            in_valid <= 1'b0;
            in_data  <= 1'b0;
        end else begin
            in_valid <= en && (cnt_q == gap);
            if (en && (cnt_q == gap)) begin
                cnt_q   <= 5'h00;
                in_data <= pat_q[7];
                pat_q   <= {pat_q[6:0], pat_q[7] ^ pat_q[5]};
            end else begin
                in_data <= ~in_data;   // No stale value between bits
                cnt_q   <= en ? cnt_q + 5'h01 : 5'h00;
            end
        end
    end
endmodule : dja_framer_model
`default_nettype wire

// File: testbench/dja_ctrl_tb_top.sv
// Self-checking testbench for the jitter attenuator control block
`timescale 1ns/1ps
`default_nettype none
module dja_ctrl_tb_top
    import dja_pkg::*;
;
    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic        rd_req;
    logic        wr_req;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic        in_valid;
    logic        in_data;
    logic        out_data;
    logic        out_strobe;
    logic        irq_n;
    logic        en;
    logic [4:0]  gap;
    logic [31:0] q;
    int          bad_count;
    int          cmp_count;
    logic        sb_on;
    logic        sb_mem [0:31];
    int          sb_wp;
    int          sb_rp;
    int          sb_cnt;
    logic        sb_iv;
    logic        sb_id;
    logic        sb_rd;
    logic        sb_wr;

    dja_ctrl dja_ctrl_i (
        .REF_CLK     (clk),
        .SYS_RST     (rst),
        .ADDRESS     (addr),
        .READ        (rd_req),
        .WRITE       (wr_req),
        .WRITEDATA   (wdata),
        .BYTEENABLE  (be),
        .READDATA    (rdata),
        .WAITREQUEST (waitreq),
        .IN_VALID    (in_valid),
        .IN_DATA     (in_data),
        .OUT_DATA    (out_data),
        .OUT_STROBE  (out_strobe),
        .IRQ_OUT_N   (irq_n)
    );

    dja_framer_model dja_framer_model_i (
        .clk      (clk),
        .rst      (rst),
        .en       (en),
        .gap      (gap),
        .in_valid (in_valid),
        .in_data  (in_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Avalon transfer held until waitrequest seen low at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] b, output logic [31:0] r);
        int   n;
        @(posedge clk);
        addr   <= a;
        rd_req <= !w;
        wr_req <= w;
        wdata  <= {24'h000000, d};
        be     <= b;
        n = 0;
        // Values seen right after the edge are those the design sampled
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        r = rdata;
        if (waitreq !== 1'b0) begin
            chk({31'h0, waitreq}, 32'h00000000);
        end
        rd_req <= 1'b0;
        wr_req <= 1'b0;
    endtask : xfer

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, 4'hF, r);
    endtask : wr8

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 8'h00, 4'hF, r);
        chk(r, {24'h000000, e});
    endtask : rchk

    // Reference FIFO for the pass-through window; pins seen one edge late
    always @(posedge clk) begin
        if (sb_on) begin
            sb_rd = out_strobe && (sb_cnt > 0);
            sb_wr = sb_iv && (sb_cnt < 32);
            if (sb_rd) begin
                chk({31'h0, out_data}, {31'h0, sb_mem[sb_rp]});
                sb_rp = (sb_rp + 1) % 32;
            end
            if (sb_wr) begin
                sb_mem[sb_wp] = sb_id;
                sb_wp         = (sb_wp + 1) % 32;
            end
            sb_cnt = sb_cnt + int'(sb_wr) - int'(sb_rd);
        end else begin
            sb_cnt = 0;
            sb_rp  = 0;
            sb_wp  = 0;
        end
        sb_iv = in_valid;
        sb_id = in_data;
    end

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles

    // Verdict and end of run
    task automatic test_done();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        bad_count = 0;
        cmp_count = 0;
        rst    = 1'b1;
        addr   = 8'h00;
        rd_req = 1'b0;
        wr_req = 1'b0;
        wdata  = 32'h00000000;
        be     = 4'h0;
        en     = 1'b0;
        gap    = 5'h00;
        sb_on  = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset values and register access
        rchk(8'h64, 8'h2F);
        rchk(8'h68, 8'h2F);
        rchk(8'h6C, 8'h23);
        rchk(8'h60, 8'h00);
        wr8(8'h64, 8'h5A);
        rchk(8'h64, 8'h5A);
        wr8(8'h68, 8'hA5);
        rchk(8'h68, 8'hA5);
        xfer(1'b1, 8'h64, 8'h11, 4'h0, q);
        rchk(8'h64, 8'h5A);
        rchk(8'h70, 8'h00);
        rchk(8'h65, 8'h00);
        wr8(8'h64, 8'h2F);
        wr8(8'h68, 8'h2F);
        // Underrun with the framer silent, interrupt masked then enabled
        cycles(800);
        rchk(8'h60, 8'h01);
        chk({31'h0, irq_n}, 32'h00000001);
        wr8(8'h6C, 8'h2B);
        cycles(25);                         // Next underrun tick sets the flag again
        chk({31'h0, irq_n}, 32'h00000000);
        wr8(8'h6C, 8'h21);
        sb_on <= 1'b1;                      // FIFO empty, reference starts level
        cycles(3);
        chk({31'h0, irq_n}, 32'h00000001);
        // Overrun with the framer sending every clock, limiting off
        wr8(8'h6C, 8'h24);
        en <= 1'b1;
        cycles(100);
        xfer(1'b0, 8'h60, 8'h00, 4'hF, q);
        chk(q & 32'h00000002, 32'h00000002);
        cycles(3);
        chk({31'h0, irq_n}, 32'h00000000);
        wr8(8'h6C, 8'h21);
        cycles(3);
        chk({31'h0, irq_n}, 32'h00000001);
        // Divisor write recentres a full FIFO when sync is set
        sb_on <= 1'b0;
        wr8(8'h6C, 8'h23);
        for (int i = 0; i < 2; i++) begin
            en <= 1'b1;
            cycles(60);
            en <= 1'b0;
            cycles(2);
            xfer(1'b0, 8'h60, 8'h00, 4'hF, q);
            wr8(8'h64 + 8'(4 * i), 8'h2F);
            en <= 1'b1;
            cycles(12);
            en <= 1'b0;
            cycles(5);
            rchk(8'h60, 8'h00);
        end
        // Self-centering switched on while full, then a draining FIFO
        wr8(8'h6C, 8'h21);
        en <= 1'b1;
        cycles(40);
        wr8(8'h6C, 8'h31);
        en <= 1'b0;
        xfer(1'b0, 8'h60, 8'h00, 4'hF, q);
        cycles(800);
        rchk(8'h60, 8'h00);
        test_done();
    end
endmodule : dja_ctrl_tb_top
`default_nettype wire
